// *** dv/pstc_stage_model.sv ***
// power stage stand-in: sense codes and gate edge counters
// assumes the bench sets sense codes just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module pstc_stage_model
	import pstc_pkg::*;
(
	// clock
	input  wire logic      i_clk,
	// gates from the controller
	input  wire pstc_gate_t i_ph1,
	input  wire pstc_gate_t i_ph2,
	// sense codes back to it
	output var pstc_sense_t o_sense
);
	logic [11:0] p1;
	logic [11:0] p2;
	logic [11:0] io;
	logic [11:0] vo;
	int          n1;
	int          n2;
	int          nr;
	int          cyc;
	int          f1;
	int          gap;
	pstc_gate_t  d1;
	pstc_gate_t  d2;
	assign o_sense = '{p1, p2, io, vo};
	// edge counts show which drives still switch
	always @(posedge i_clk) begin
		d1 <= i_ph1;
		d2 <= i_ph2;
		cyc++;
		// cycles from a phase one trailing edge to the next phase two one
		if (!i_ph1.bridge_hi && d1.bridge_hi)
			f1 = cyc;
		if (!i_ph2.bridge_hi && d2.bridge_hi)
			gap = cyc - f1;
		if (i_ph1.bridge_hi && !d1.bridge_hi)
			n1++;
		if (i_ph2.bridge_hi && !d2.bridge_hi)
			n2++;
		if ((i_ph1.rect_a && !d1.rect_a) || (i_ph2.rect_a && !d2.rect_a))
			nr++;
	end
endmodule
`default_nettype wire

// *** dv/tb_pstc_top.sv ***
// bench for the phase shed and trip controller
// assumes zero-wait apb and a tick every TICK_CYC cycles
`timescale 1ns/1ps
`default_nettype none
module tb_pstc_top;
	import pstc_pkg::*;
	logic        clk, rst, psel, pen, pwr, rdy, err, rerr, trip, tev, imb, tick;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  m0;
	pstc_sense_t sense;
	pstc_gate_t  g1, g2;
	int          fails, cmp_count;
`define M pstc_stage_model_inst
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

	pstc_top pstc_top_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PREADY(rdy), .O_PSLVERR(err), .O_PRDATA(prdata), .I_SENSE(sense),
		.O_PHASE_ONE(g1), .O_PHASE_TWO(g2), .O_TRIP(trip), .O_TRIP_EVENT(tev),
		.O_IMBALANCE(imb), .O_TICK(tick));
	pstc_stage_model pstc_stage_model_inst (.i_clk(clk), .i_ph1(g1), .i_ph2(g2),
		.o_sense(sense));

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// entered just after a rising edge, leaves just after one
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (rdy === 1'b1)
				break;
		end
		if (n == 16) begin
			fails++;
			give_verdict();
		end
		rd = prdata;
		rerr = err;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_tick();
		int n;
		for (n = 0; n < 1000; n++) begin
			@(posedge clk);
			#1;
			if (tick === 1'b1)
				break;
		end
		if (n == 1000) begin
			fails++;
			give_verdict();
		end
		repeat (3) @(posedge clk);
	endtask

	task automatic settle();
		`M.n1 = 0;
		`M.n2 = 0;
		`M.nr = 0;
		repeat (400) @(posedge clk);
	endtask

	task automatic t_regs();
		// shed and rectifier thresholds left at defaults, which keep their gap
		apb(0, OFS_SHED_LO, 0);
		`CHK(rd[11:0], RST_SHED_LO)
		apb(0, OFS_SHED_HI, 0);
		`CHK(rd[11:0], RST_SHED_HI)
		apb(0, OFS_SR_LO, 0);
		`CHK(rd[11:0], RST_SR_LO)
		apb(0, OFS_SR_HI, 0);
		`CHK(rd[11:0], RST_SR_HI)
		apb(0, OFS_TRIP_P1, 0);
		`CHK(rd[11:0], RST_TRIP)
		apb(1, OFS_TRIP_VO, 32'h1abc);
		apb(0, OFS_TRIP_VO, 0);
		`CHK(rd, 32'h0abc)
		apb(0, 8'hfc, 0);
		`CHK(rerr, 1'b1)
		$display("test regs done");
	endtask

	task automatic t_tick();
		int n;
		wait_tick();
		for (n = 3; n < 900; n++) begin
			@(posedge clk);
			#1;
			if (tick === 1'b1)
				break;
		end
		`CHK(n + 1, TICK_CYC)
		@(posedge clk);
		$display("test tick done");
	endtask

	task automatic t_imb();
		`M.p1 <= 12'h1f4;
		`M.p2 <= 12'h12c;
		`M.vo <= 12'h7d0;
		wait_tick();
		`CHK(imb, 1'b1)
		apb(0, OFS_VOUT, 0);
		`CHK(rd, 32'h0000_07d0)
		`M.p2 <= 12'h1c2;
		wait_tick();
		`CHK(imb, 1'b0)
		$display("test balance done");
	endtask

	task automatic t_shed();
		apb(0, OFS_STATUS, 0);
		m0 = rd[5:3];
		`M.io <= 12'h384;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[2], 1'b0)
		`CHK(rd[5:3] != m0, 1'b1)
		settle();
		`CHK(`M.n1 > 0 && `M.n2 > 0, 1'b1)
		`M.io <= 12'h44c;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[5:3] != m0, 1'b1)
		`M.io <= 12'h514;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[5:3], m0)
		settle();
		`CHK(`M.n1 > 0 && `M.n2 > 0, 1'b1)
		`M.io <= 12'h384;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[2], 1'b1)
		$display("test shed done");
	endtask

	task automatic t_sr();
		`M.io <= 12'h096;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[1], 1'b0)
		settle();
		`CHK(`M.nr, 0)
		`M.io <= 12'h0fa;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[1], 1'b0)
		`M.io <= 12'h15e;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[1], 1'b1)
		settle();
		`CHK(`M.nr > 0, 1'b1)
		`CHK(`M.gap, RST_PERIOD >> 1)
		$display("test rectifier done");
	endtask

	task automatic t_shed_full();
		int k;
		apb(1, OFS_PERIOD, 32'h0000_0020);
		`M.io <= 12'h514;
		wait_tick();
		`M.io <= 12'h384;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[2], 1'b0)
		for (k = 0; k < 24; k++) begin
			wait_tick();
			apb(0, OFS_STATUS, 0);
			if (rd[5:3] === 3'b100)
				break;
		end
		`CHK(rd[5:3], 3'b100)
		settle();
		`CHK(`M.n1, 0)
		`CHK(`M.n2 > 0, 1'b1)
		`M.io <= 12'h514;
		wait_tick();
		apb(0, OFS_STATUS, 0);
		`CHK(rd[5:3], 3'b001)
		settle();
		`CHK(`M.n1 > 0 && `M.n2 > 0, 1'b1)
		$display("test full shed done");
	endtask

	task automatic t_trip();
		`M.io <= 12'h050;
		apb(1, OFS_TRIP_IO, 32'h100);
		`M.io <= 12'h200;
		@(posedge clk);
		#1;
		`CHK(trip, 1'b1)
		`CHK(tev, 1'b1)
		`CHK({g1, g2}, 8'h00)
		@(posedge clk);
		#1;
		`CHK(tev, 1'b0)
		@(posedge clk);
		`M.io <= 12'h050;
		wait_tick();
		`CHK(trip, 1'b1)
		`CHK({g1, g2}, 8'h00)
		apb(0, OFS_STATUS, 0);
		`CHK(rd[1:0], 2'b01)
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(trip, 1'b0)
		$display("test trip done");
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		{rst, psel, pen, pwr, paddr, pwdata} = {3'b100, 41'h0};
		{`M.p1, `M.p2, `M.io, `M.vo} = {12'h0, 12'h0, 12'h5dc, 12'h0};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_tick();
		t_imb();
		t_shed();
		t_sr();
		t_shed_full();
		t_trip();
		give_verdict();
	end
endmodule
`default_nettype wire

// *** hw/pstc_phase_pwm.sv ***
// one phase: complementary bridge pair with dead time and two rectifier drives
// assumes a down count per period; trailing edge fixed where it reaches zero
`timescale 1ns/1ps
`default_nettype none
module pstc_phase_pwm
	import pstc_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// timing
	input  wire logic [11:0] i_count,
	input  wire logic [11:0] i_on_len,
	input  wire logic        i_en,
	input  wire logic        i_sr_en,
	input  wire logic        i_kill,
	// gates
	output pstc_gate_t       o_gate
);
	logic        hi_raw;
	logic [11:0] dead;
	logic        prev;
	logic        quiet;

	// on window ends at count zero, so falling edges follow the counter phase
	assign hi_raw = i_en && (i_count < i_on_len);
	// the edge cycle itself is dead too, else the other side turns on at once
	assign quiet = (prev == hi_raw) && (dead == 12'h000);

	always_ff @(posedge i_clk) begin
		if (i_rst || i_kill) begin
			dead <= 12'h000;
			prev <= 1'b0;
		end else begin
			prev <= hi_raw;
			if (prev != hi_raw)
				dead <= 12'(DEAD_CYC);
			else if (dead != 12'h000)
				dead <= dead - 12'h001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || i_kill) begin
			o_gate <= '0;
		end else begin
			o_gate.bridge_hi <= hi_raw && quiet && i_en;
			o_gate.bridge_lo <= !hi_raw && quiet && i_en;
			o_gate.rect_a    <= hi_raw && quiet && i_en && i_sr_en;
			o_gate.rect_b    <= !hi_raw && quiet && i_en && i_sr_en;
		end
	end

	dead_pair_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!(o_gate.bridge_hi && o_gate.bridge_lo)) else $error("bridge pair overlap");
	dead_gap_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_gate.bridge_hi) |-> !o_gate.bridge_lo [*4]) else $error("no dead time after high side");
endmodule
`default_nettype wire

// *** hw/pstc_pkg.sv ***
// package for the phase shed and trip controller: register map, timing, carriers
// assumes a 40 MHz system clock and 12-bit sampled feedback codes
package pstc_pkg;
	localparam int unsigned CLK_HZ   = 40_000_000;
	localparam int unsigned TICK_HZ  = 50_000;
	localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
	localparam int unsigned DEAD_NS  = 100;
	localparam int unsigned DEAD_CYC = (DEAD_NS * 40 + 999) / 1000;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_SHED_LO  = 8'h04;
	localparam logic [7:0] OFS_SHED_HI  = 8'h08;
	localparam logic [7:0] OFS_SR_LO    = 8'h0c;
	localparam logic [7:0] OFS_SR_HI    = 8'h10;
	localparam logic [7:0] OFS_BAL_TH   = 8'h14;
	localparam logic [7:0] OFS_TRIP_P1  = 8'h18;
	localparam logic [7:0] OFS_TRIP_IO  = 8'h1c;
	localparam logic [7:0] OFS_TRIP_VO  = 8'h20;
	localparam logic [7:0] OFS_TRIP_P2  = 8'h24;
	localparam logic [7:0] OFS_PERIOD   = 8'h28;
	localparam logic [7:0] OFS_STATUS   = 8'h2c;
	localparam logic [7:0] OFS_VOUT     = 8'h30;

	// resets, current codes at 1 lsb per 10 mA
	localparam logic [11:0] RST_SHED_LO = 12'h3e8;
	localparam logic [11:0] RST_SHED_HI = 12'h4b0;
	localparam logic [11:0] RST_SR_LO   = 12'h0c8;
	localparam logic [11:0] RST_SR_HI   = 12'h12c;
	localparam logic [11:0] RST_BAL_TH  = 12'h064;
	localparam logic [11:0] RST_TRIP    = 12'hfff;
	localparam logic [11:0] RST_PERIOD  = 12'h0a0;
	localparam logic [11:0] RAMP_STEP   = 12'h001;
	localparam logic [2:0]  RST_CTRL    = 3'h7;

	// ctrl fields
	localparam int CTRL_RUN  = 0;
	localparam int CTRL_SHED = 1;
	localparam int CTRL_SR   = 2;

	typedef struct packed {
		logic [11:0] phase_one;
		logic [11:0] phase_two;
		logic [11:0] out_cur;
		logic [11:0] out_volt;
	} pstc_sense_t;

	typedef struct packed {
		logic bridge_hi;
		logic bridge_lo;
		logic rect_a;
		logic rect_b;
	} pstc_gate_t;
endpackage

// *** hw/pstc_top.sv ***
// phase shedding, rectifier disable and trip latch for a two-phase converter
// assumes APB master on the system clock; comparator levels from sampled codes
`timescale 1ns/1ps
`default_nettype none
module pstc_top
	import pstc_pkg::*;
(
	// clock and reset
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_RST,
	// apb slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	output logic [31:0]      O_PRDATA,
	// sampled feedback
	input  wire pstc_pkg::pstc_sense_t I_SENSE,
	// gate drives
	output pstc_gate_t       O_PHASE_ONE,
	output pstc_gate_t       O_PHASE_TWO,
	// status
	output logic             O_TRIP,
	output logic             O_TRIP_EVENT,
	output logic             O_IMBALANCE,
	output logic             O_TICK
);
	import pstc_pkg::*;

	typedef enum logic [2:0] {
		ST_BOTH = 3'b001,
		ST_WIND = 3'b010,
		ST_SHED = 3'b100
	} pstc_mode_t;

	logic [2:0]  ctrl;
	logic [11:0] shed_lo, shed_hi, sr_lo, sr_hi, bal_th, period;
	logic [11:0] trip_p1, trip_io, trip_vo, trip_p2;
	logic [11:0] vout;
	logic [15:0] tick_cnt;
	logic        tick;
	logic        trip;
	logic        over;
	logic        sr_en;
	logic        shed_sel;
	logic        imbalance;
	logic [11:0] diff;
	logic [11:0] ramp;
	logic [11:0] cnt;
	logic [11:0] cnt_two;
	logic [11:0] dn_one, dn_two;
	logic [11:0] on_one, on_two;
	logic        en_one, en_two;
	logic        wr, rd;
	logic        hit;
	pstc_mode_t  mode;

	// apb: zero wait state, unmapped address answers slverr
	assign wr = I_PSEL && I_PENABLE && I_PWRITE;
	assign rd = I_PSEL && !I_PWRITE;
	assign O_PREADY = 1'b1;
	always_comb begin
		hit = 1'b1;
		unique case (I_PADDR)
			OFS_CTRL, OFS_SHED_LO, OFS_SHED_HI, OFS_SR_LO, OFS_SR_HI, OFS_BAL_TH,
			OFS_TRIP_P1, OFS_TRIP_IO, OFS_TRIP_VO, OFS_TRIP_P2, OFS_PERIOD,
			OFS_STATUS, OFS_VOUT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			ctrl    <= RST_CTRL;
			shed_lo <= RST_SHED_LO;
			shed_hi <= RST_SHED_HI;
			sr_lo   <= RST_SR_LO;
			sr_hi   <= RST_SR_HI;
			bal_th  <= RST_BAL_TH;
			trip_p1 <= RST_TRIP;
			trip_io <= RST_TRIP;
			trip_vo <= RST_TRIP;
			trip_p2 <= RST_TRIP;
			period  <= RST_PERIOD;
		end else if (wr) begin
			unique case (I_PADDR)
				OFS_CTRL:    ctrl    <= I_PWDATA[2:0];
				OFS_SHED_LO: shed_lo <= I_PWDATA[11:0];
				OFS_SHED_HI: shed_hi <= I_PWDATA[11:0];
				OFS_SR_LO:   sr_lo   <= I_PWDATA[11:0];
				OFS_SR_HI:   sr_hi   <= I_PWDATA[11:0];
				OFS_BAL_TH:  bal_th  <= I_PWDATA[11:0];
				OFS_TRIP_P1: trip_p1 <= I_PWDATA[11:0];
				OFS_TRIP_IO: trip_io <= I_PWDATA[11:0];
				OFS_TRIP_VO: trip_vo <= I_PWDATA[11:0];
				OFS_TRIP_P2: trip_p2 <= I_PWDATA[11:0];
				OFS_PERIOD:  period  <= I_PWDATA[11:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (rd) begin
			unique case (I_PADDR)
				OFS_CTRL:    O_PRDATA <= {29'h0, ctrl};
				OFS_SHED_LO: O_PRDATA <= {20'h0, shed_lo};
				OFS_SHED_HI: O_PRDATA <= {20'h0, shed_hi};
				OFS_SR_LO:   O_PRDATA <= {20'h0, sr_lo};
				OFS_SR_HI:   O_PRDATA <= {20'h0, sr_hi};
				OFS_BAL_TH:  O_PRDATA <= {20'h0, bal_th};
				OFS_TRIP_P1: O_PRDATA <= {20'h0, trip_p1};
				OFS_TRIP_IO: O_PRDATA <= {20'h0, trip_io};
				OFS_TRIP_VO: O_PRDATA <= {20'h0, trip_vo};
				OFS_TRIP_P2: O_PRDATA <= {20'h0, trip_p2};
				OFS_PERIOD:  O_PRDATA <= {20'h0, period};
				OFS_STATUS:  O_PRDATA <= {26'h0, mode, shed_sel, sr_en, trip};
				OFS_VOUT:    O_PRDATA <= {20'h0, vout};
				default:     O_PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// fixed control tick
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST || tick_cnt == 16'(TICK_CYC - 1))
			tick_cnt <= 16'h0000;
		else
			tick_cnt <= tick_cnt + 16'h0001;
	end
	assign tick = (tick_cnt == 16'(TICK_CYC - 1));
	assign O_TICK = tick;

	// output voltage sampled once per tick for the loop
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST)
			vout <= 12'h000;
		else if (tick)
			vout <= I_SENSE.out_volt;
	end

	// protection: any over-level trips, latched until reset
	assign over = (I_SENSE.phase_one > trip_p1) || (I_SENSE.out_cur > trip_io) ||
		(I_SENSE.out_volt > trip_vo) || (I_SENSE.phase_two > trip_p2);
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			trip         <= 1'b0;
			O_TRIP_EVENT <= 1'b0;
		end else begin
			trip         <= trip || over;
			O_TRIP_EVENT <= over && !trip;
		end
	end
	assign O_TRIP = trip;

	// balance: absolute primary current difference
	assign diff = (I_SENSE.phase_one > I_SENSE.phase_two) ?
		I_SENSE.phase_one - I_SENSE.phase_two : I_SENSE.phase_two - I_SENSE.phase_one;
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST)
			imbalance <= 1'b0;
		else if (tick)
			imbalance <= diff > bal_th;
	end
	assign O_IMBALANCE = imbalance;

	// rectifier hysteresis, evaluated per tick
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST)
			sr_en <= 1'b1;
		else if (trip || !ctrl[CTRL_SR])
			sr_en <= 1'b0;
		else if (tick && sr_en && I_SENSE.out_cur < sr_lo)
			sr_en <= 1'b0;
		else if (tick && !sr_en && I_SENSE.out_cur > sr_hi)
			sr_en <= 1'b1;
	end

	// shedding state machine; ramp shrinks the shed phase on-time per tick
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			mode     <= ST_BOTH;
			shed_sel <= 1'b1;
			ramp     <= 12'h000;
		end else if (tick && !trip) begin
			unique case (mode)
				ST_BOTH: begin
					if (ctrl[CTRL_SHED] && I_SENSE.out_cur < shed_lo) begin
						mode     <= ST_WIND;
						shed_sel <= !shed_sel;
						ramp     <= period >> 1;
					end
				end
				ST_WIND: begin
					if (I_SENSE.out_cur > shed_hi) begin
						mode <= ST_BOTH;
					end else if (ramp <= RAMP_STEP) begin
						ramp <= 12'h000;
						mode <= ST_SHED;
					end else begin
						ramp <= ramp - RAMP_STEP;
					end
				end
				ST_SHED: begin
					if (I_SENSE.out_cur > shed_hi || !ctrl[CTRL_SHED])
						mode <= ST_BOTH;
				end
				default: mode <= ST_BOTH;
			endcase
		end
	end

	// shared period counter; phase two counter offset by half a period
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST || cnt >= period - 12'h001)
			cnt <= 12'h000;
		else
			cnt <= cnt + 12'h001;
	end
	assign cnt_two = (cnt >= (period >> 1)) ? cnt - (period >> 1) : cnt + period - (period >> 1);
	// down counts end every on window at the wrap, whatever its length
	assign dn_one = period - 12'h001 - cnt;
	assign dn_two = period - 12'h001 - cnt_two;

	always_comb begin
		on_one = period >> 1;
		on_two = period >> 1;
		if (mode == ST_WIND) begin
			if (shed_sel)
				on_two = ramp;
			else
				on_one = ramp;
		end
	end
	assign en_one = ctrl[CTRL_RUN] && !(mode == ST_SHED && !shed_sel);
	assign en_two = ctrl[CTRL_RUN] && !(mode == ST_SHED && shed_sel);

	pstc_phase_pwm u_one (
		.i_clk    (I_CLK_SYS),
		.i_rst    (I_RST),
		.i_count  (dn_one),
		.i_on_len (on_one),
		.i_en     (en_one),
		.i_sr_en  (sr_en),
		.i_kill   (trip || over),
		.o_gate   (O_PHASE_ONE)
	);
	pstc_phase_pwm u_two (
		.i_clk    (I_CLK_SYS),
		.i_rst    (I_RST),
		.i_count  (dn_two),
		.i_on_len (on_two),
		.i_en     (en_two),
		.i_sr_en  (sr_en),
		.i_kill   (trip || over),
		.o_gate   (O_PHASE_TWO)
	);

	trip_latch_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		trip |=> trip) else $error("trip latch released");
	trip_gates_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		trip |=> (O_PHASE_ONE == '0) && (O_PHASE_TWO == '0)) else $error("gates high in trip");
	trip_set_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		over |=> trip) else $error("over level not latched");
	tick_period_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		tick |=> !tick [*8]) else $error("tick too frequent");
	shed_entry_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(tick && !trip && mode == ST_BOTH && ctrl[CTRL_SHED] && I_SENSE.out_cur < shed_lo)
		|=> mode == ST_WIND && shed_sel != $past(shed_sel)) else $error("shed entry wrong");
	shed_exit_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(tick && !trip && mode == ST_SHED && I_SENSE.out_cur > shed_hi)
		|=> mode == ST_BOTH) else $error("shed exit missed");
	sr_off_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(tick && !trip && ctrl[CTRL_SR] && sr_en && I_SENSE.out_cur < sr_lo)
		|=> !sr_en) else $error("rectifier not disabled");
	sr_on_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(tick && !trip && ctrl[CTRL_SR] && !sr_en && I_SENSE.out_cur > sr_hi)
		|=> sr_en) else $error("rectifier not enabled");
	sr_trip_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		trip |=> !sr_en) else $error("rectifier on after trip");
endmodule
`default_nettype wire
